// File: rtl/adc_cycle_pkg.sv
// constants shared by the conversion-cycle sequencer
// assumes a 20 MHz system clock and a 24-bit serial output word
package adc_cycle_pkg;
	localparam int WORD_BITS    = 24;
	localparam int CFG_BITS     = 16;
	localparam int RAW_BITS     = 20;
	localparam int CLK_HZ       = 20_000_000;
	localparam int POR_TIME_US  = 4000;
	// approximate pulse, so plain truncation is fine
	localparam int POR_CYCLES   = POR_TIME_US * (CLK_HZ / 1_000_000);
	localparam int CONV_CYCLES  = 2048;
	localparam int SCK_HALF     = 10;
	// configuration word, first bit received lands in bit 15
	localparam int CFG_CHAN_EN  = 15;
	localparam int CFG_SGL      = 14;
	localparam int CFG_ODD      = 13;
	localparam int CFG_ADDR_LSB = 10;
	localparam int CFG_MODE_EN  = 9;
	localparam int CFG_TEMP     = 8;
	localparam int CFG_REJ_LSB  = 6;
	localparam int CFG_SPD      = 5;
	localparam int CFG_GAIN_LSB = 2;
	// values after power-on clear: ch0(+)/ch1(-), 50/60 Hz, 1x, gain 1
	localparam logic [4:0] CHAN_RST = 5'h00;
	localparam logic [1:0] REJ_RST  = 2'h0;
	localparam logic [2:0] GAIN_RST = 3'h0;
	// result clamp: +FS+1LSB and -FS-1LSB in lsb units
	localparam logic signed [17:0] CODE_MAX = 18'sh1_0000;
	localparam logic signed [17:0] CODE_MIN = -18'sh1_0001;
	typedef enum {st_clear, st_convert, st_sleep, st_io} cycle_state_type;
	typedef enum logic [1:0] {
		cal_offset, cal_fullscale, cal_sample
	} cal_phase_type;
endpackage

// File: rtl/adc_serial_conversion_cycle.sv
// conversion / sleep / data input-output sequencer with 3/4-wire port
// assumes the pad resolves shift_clock from its enable and a pull-up,
// and feeds the pin level back on shift_clock_in
`timescale 1ns/1ps

// two-flop synchroniser, one per bit
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

module adc_serial_conversion_cycle #(
	parameter int POR_CYCLES  = adc_cycle_pkg::POR_CYCLES,
	parameter int CONV_CYCLES = adc_cycle_pkg::CONV_CYCLES,
	parameter int SCK_HALF    = adc_cycle_pkg::SCK_HALF
) (
	input  wire logic                                  clk,
	input  wire logic                                  rst_n,
	input  wire logic                                  supply_ok,
	input  wire logic                                  select_n,
	input  wire logic                                  shift_clock_in,
	output logic                                       shift_clock_out,
	output logic                                       shift_clock_oe,
	input  wire logic                                  serial_in,
	output logic                                       serial_out,
	output logic                                       serial_out_oe,
	input  wire logic signed [adc_cycle_pkg::RAW_BITS-1:0] conv_raw,
	output logic                                       power_on_clear,
	output logic                                       converting,
	output logic                                       sleeping,
	output adc_cycle_pkg::cal_phase_type               cal_phase,
	output logic                                       internal_clock_mode,
	output logic                          [4:0]        channel_sel,
	output logic                          [1:0]        rejection,
	output logic                                       speed_2x,
	output logic                                       temp_sensor,
	output logic                          [2:0]        gain
);
	localparam int WB = adc_cycle_pkg::WORD_BITS;
	localparam int CB = adc_cycle_pkg::CFG_BITS;
	localparam int RAW_BITS     = adc_cycle_pkg::RAW_BITS;
	localparam int CFG_MODE_EN  = adc_cycle_pkg::CFG_MODE_EN;
	localparam int CFG_ADDR_LSB = adc_cycle_pkg::CFG_ADDR_LSB;
	localparam int CFG_SGL      = adc_cycle_pkg::CFG_SGL;

	if (POR_CYCLES < 1 || POR_CYCLES >= (1 << 20))
		$error("POR_CYCLES out of range");
	if (CONV_CYCLES < 3 || CONV_CYCLES >= (1 << 16))
		$error("CONV_CYCLES out of range");
	if (SCK_HALF < 1 || SCK_HALF >= (1 << 8))
		$error("SCK_HALF out of range");

	// ---------------- link domain (shift_clock pin) ----------------
	logic [4:0]    rise_cnt_q;
	logic [4:0]    fall_cnt_q;
	logic          start_tgl_q;
	logic          done_tgl_q;
	logic [CB-1:0] cfg_shift_q;
	logic          cfg_full_q;

	// select_n high clears the frame counters; no clock edge is needed
	always_ff @(posedge shift_clock_in or posedge select_n or negedge rst_n) begin
		if (!rst_n || select_n) begin
			rise_cnt_q <= 5'h00;
		end else if (rise_cnt_q < 5'(WB)) begin
			rise_cnt_q <= rise_cnt_q + 5'h01;
		end
	end

	// a falling edge only counts after a rising one, so the pad going
	// from pulled-up to driven-low in internal mode shifts nothing
	always_ff @(negedge shift_clock_in or posedge select_n or negedge rst_n) begin
		if (!rst_n || select_n) begin
			fall_cnt_q <= 5'h00;
		end else if (rise_cnt_q > fall_cnt_q && fall_cnt_q < 5'(WB)) begin
			fall_cnt_q <= fall_cnt_q + 5'h01;
		end
	end

	// configuration shift-in; survives the frame for the clk side
	always_ff @(posedge shift_clock_in or negedge rst_n) begin
		if (!rst_n) begin
			cfg_shift_q <= '0;
			cfg_full_q  <= 1'b0;
			start_tgl_q <= 1'b0;
		end else if (!select_n) begin
			if (rise_cnt_q < 5'(CB))
				cfg_shift_q <= {cfg_shift_q[CB-2:0], serial_in};
			if (rise_cnt_q == 5'h00) begin
				start_tgl_q <= ~start_tgl_q;
				cfg_full_q  <= 1'b0;
			end else if (rise_cnt_q == 5'(CB - 1)) begin
				cfg_full_q  <= 1'b1;
			end
		end
	end

	// event: 24th falling edge, word fully read
	always_ff @(negedge shift_clock_in or negedge rst_n) begin
		if (!rst_n) begin
			done_tgl_q <= 1'b0;
		end else if (!select_n && fall_cnt_q == 5'(WB - 1) &&
			rise_cnt_q == 5'(WB)) begin
			done_tgl_q <= ~done_tgl_q;
		end
	end

	// ---------------- system clock domain ----------------
	adc_cycle_pkg::cycle_state_type state_q;
	logic [4:0]          sync_s;
	logic                cs_s;
	logic                sck_s;
	logic                sup_s;
	logic                cs_prev_q;
	logic                start_prev_q;
	logic                done_prev_q;
	logic                start_ev;
	logic                done_ev;
	logic                started_q;
	logic [19:0]         por_cnt_q;
	logic [15:0]         conv_cnt_q;
	logic                pending_q;
	logic [WB-1:0]       word_q;
	logic [CB-1:0]       cfg_act_q;
	logic                mode_int_q;
	logic [7:0]          div_cnt_q;
	logic [4:0]          pulse_cnt_q;
	logic                sck_out_q;
	logic                sck_oe_q;
	logic                sdo_oe_q;
	logic signed [17:0]  code;

	// toggles are read only once synchronised; select_n enters inverted
	// so the cleared synchroniser reads as deselected, not as a select
	bit_sync #(
		.WIDTH(5)
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.async_in({~select_n, shift_clock_in, supply_ok,
			start_tgl_q, done_tgl_q}),
		.sync_out(sync_s)
	);
	assign cs_s  = ~sync_s[4];
	assign sck_s = sync_s[3];
	assign sup_s = sync_s[2];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs_prev_q    <= 1'b1;
			start_prev_q <= 1'b0;
			done_prev_q  <= 1'b0;
		end else begin
			cs_prev_q    <= cs_s;
			start_prev_q <= sync_s[1];
			done_prev_q  <= sync_s[0];
		end
	end
	assign start_ev = sync_s[1] ^ start_prev_q;
	assign done_ev  = sync_s[0] ^ done_prev_q;

	// clamp to one lsb beyond full scale
	always_comb begin
		if (conv_raw > RAW_BITS'(adc_cycle_pkg::CODE_MAX))
			code = adc_cycle_pkg::CODE_MAX;
		else if (conv_raw < RAW_BITS'(adc_cycle_pkg::CODE_MIN))
			code = adc_cycle_pkg::CODE_MIN;
		else
			code = conv_raw[17:0];
	end

	// cycle sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= adc_cycle_pkg::st_clear;
		end else begin
			case (state_q)
				adc_cycle_pkg::st_clear:
					if (sup_s && por_cnt_q == 20'(POR_CYCLES - 1))
						state_q <= adc_cycle_pkg::st_convert;
				adc_cycle_pkg::st_convert:
					if (!sup_s)
						state_q <= adc_cycle_pkg::st_clear;
					else if (conv_cnt_q == 16'(CONV_CYCLES - 1))
						state_q <= adc_cycle_pkg::st_sleep;
				adc_cycle_pkg::st_sleep:
					if (!sup_s)
						state_q <= adc_cycle_pkg::st_clear;
					else if (!cs_s)
						state_q <= adc_cycle_pkg::st_io;
				adc_cycle_pkg::st_io:
					if (!sup_s)
						state_q <= adc_cycle_pkg::st_clear;
					else if (done_ev)
						state_q <= adc_cycle_pkg::st_convert;
					else if (cs_s && (started_q || start_ev))
						state_q <= adc_cycle_pkg::st_convert;
					else if (cs_s)
						state_q <= adc_cycle_pkg::st_sleep;
				default:
					state_q <= adc_cycle_pkg::st_clear;
			endcase
		end
	end

	// clear pulse timer; restarts whenever the supply dips
	always_ff @(posedge clk) begin
		if (!rst_n || !sup_s || state_q != adc_cycle_pkg::st_clear)
			por_cnt_q <= 20'h0_0000;
		else if (por_cnt_q != 20'(POR_CYCLES - 1))
			por_cnt_q <= por_cnt_q + 20'h0_0001;
	end

	// conversion timer; thirds give offset, full-scale, sample phases
	always_ff @(posedge clk) begin
		if (!rst_n || state_q != adc_cycle_pkg::st_convert)
			conv_cnt_q <= 16'h0000;
		else
			conv_cnt_q <= conv_cnt_q + 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			cal_phase <= adc_cycle_pkg::cal_offset;
		else if (conv_cnt_q < 16'(CONV_CYCLES / 3))
			cal_phase <= adc_cycle_pkg::cal_offset;
		else if (conv_cnt_q < 16'((2 * CONV_CYCLES) / 3))
			cal_phase <= adc_cycle_pkg::cal_fullscale;
		else
			cal_phase <= adc_cycle_pkg::cal_sample;
	end

	// io frame saw its first rising edge
	always_ff @(posedge clk) begin
		if (!rst_n || state_q != adc_cycle_pkg::st_io)
			started_q <= 1'b0;
		else if (start_ev)
			started_q <= 1'b1;
	end

	// result word: written only at conversion end and zeroed in clear, so it is static
	// whenever the link side reads it
	always_ff @(posedge clk) begin
		if (!rst_n || state_q == adc_cycle_pkg::st_clear) begin
			word_q <= '0;
		end else if (state_q == adc_cycle_pkg::st_convert &&
			conv_cnt_q == 16'(CONV_CYCLES - 1)) begin
			word_q <= {2'h0, ~code[17], code[16:0], 4'h0};
		end
	end

	// pending flag: drops on the last conversion cycle so sleep shows done
	always_ff @(posedge clk) begin
		if (!rst_n || !sup_s || state_q == adc_cycle_pkg::st_clear)
			pending_q <= 1'b1;
		else
			pending_q <= state_q == adc_cycle_pkg::st_convert &&
				conv_cnt_q != 16'(CONV_CYCLES - 1);
	end

	// configuration: link shift register is quiet once the frame ended
	always_ff @(posedge clk) begin
		if (!rst_n || state_q == adc_cycle_pkg::st_clear) begin
			cfg_act_q <= {1'b0, adc_cycle_pkg::CHAN_RST, 2'h0,
				adc_cycle_pkg::REJ_RST, 1'b0, adc_cycle_pkg::GAIN_RST,
				2'h0};
		end else if (state_q == adc_cycle_pkg::st_io &&
			(done_ev || (cs_s && (started_q || start_ev))) && cfg_full_q) begin
			if (cfg_shift_q[adc_cycle_pkg::CFG_CHAN_EN])
				cfg_act_q[CB-1:CFG_MODE_EN+1] <=
					cfg_shift_q[CB-1:CFG_MODE_EN+1];
			if (cfg_shift_q[CFG_MODE_EN])
				cfg_act_q[CFG_MODE_EN:0] <= cfg_shift_q[CFG_MODE_EN:0];
		end
	end

	// clock mode: pin level at power-up and at each select_n fall
	always_ff @(posedge clk) begin
		if (!rst_n || state_q == adc_cycle_pkg::st_clear)
			mode_int_q <= sck_s;
		else if (cs_prev_q && !cs_s)
			mode_int_q <= sck_s;
	end

	// internal clock generator, 24 pulses then idle low
	always_ff @(posedge clk) begin
		if (!rst_n || state_q != adc_cycle_pkg::st_io || !mode_int_q || cs_s) begin
			div_cnt_q   <= 8'h00;
			pulse_cnt_q <= 5'h00;
			sck_out_q   <= 1'b0;
		end else if (pulse_cnt_q < 5'(WB)) begin
			if (div_cnt_q == 8'(SCK_HALF - 1)) begin
				div_cnt_q <= 8'h00;
				sck_out_q <= ~sck_out_q;
				if (sck_out_q)
					pulse_cnt_q <= pulse_cnt_q + 5'h01;
			end else begin
				div_cnt_q <= div_cnt_q + 8'h01;
			end
		end
	end

	// pad enables follow the synchronised select_n
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sck_oe_q <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			sck_oe_q <= mode_int_q && !cs_s &&
				state_q == adc_cycle_pkg::st_io;
			sdo_oe_q <= !cs_s;
		end
	end

	// serial_out: status before the first fall, word bits after,
	// and high again once the 24th fall starts the next conversion
	always_comb begin
		if (fall_cnt_q == 5'h00)
			serial_out = pending_q;
		else if (fall_cnt_q >= 5'(WB))
			serial_out = 1'b1;
		else
			serial_out = word_q[5'(WB - 1) - fall_cnt_q];
	end

	assign serial_out_oe       = sdo_oe_q;
	assign shift_clock_out     = sck_out_q;
	assign shift_clock_oe      = sck_oe_q;
	assign internal_clock_mode = mode_int_q;
	assign power_on_clear      = state_q == adc_cycle_pkg::st_clear;
	assign converting          = state_q == adc_cycle_pkg::st_convert;
	assign sleeping            = state_q == adc_cycle_pkg::st_sleep;
	assign channel_sel = cfg_act_q[CFG_SGL:CFG_ADDR_LSB];
	assign temp_sensor = cfg_act_q[adc_cycle_pkg::CFG_TEMP];
	assign rejection   = cfg_act_q[adc_cycle_pkg::CFG_REJ_LSB +: 2];
	assign speed_2x    = cfg_act_q[adc_cycle_pkg::CFG_SPD];
	assign gain        = cfg_act_q[adc_cycle_pkg::CFG_GAIN_LSB +: 3];
endmodule

// File: sim/adc_cycle_monitor.sv
// checker: time relations on the sequencer's top-level ports
// assumes rst_n is held low for some clocks before the first check
`timescale 1ns/1ps
module adc_cycle_monitor (
	input logic                         clk,
	input logic                         rst_n,
	input logic                         supply_ok,
	input logic                         select_n,
	input logic                         shift_clock_in,
	input logic                         shift_clock_out,
	input logic                         shift_clock_oe,
	input logic                         serial_in,
	input logic                         serial_out,
	input logic                         serial_out_oe,
	input logic signed [19:0]           conv_raw,
	input logic                         power_on_clear,
	input logic                         converting,
	input logic                         sleeping,
	input adc_cycle_pkg::cal_phase_type cal_phase,
	input logic                         internal_clock_mode,
	input logic [4:0]                   channel_sel,
	input logic [1:0]                   rejection,
	input logic                         speed_2x,
	input logic                         temp_sensor,
	input logic [2:0]                   gain
);
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_conv_after_clear: assert property (
		$fell(power_on_clear) |-> converting) else $error("no conversion");
	a_sleep_after_conv: assert property (
		$fell(converting) |-> sleeping || power_on_clear) else $error("no sleep");
	// select and supply pass two sync flops, hence five quiet samples
	a_sleep_holds: assert property (
		(select_n && supply_ok)[*5] ##0 sleeping |=> sleeping)
		else $error("sleep left");
	a_wake_on_select: assert property (
		sleeping && $fell(select_n) ##1 !select_n[*4] |-> !sleeping)
		else $error("no wake");
	a_out_enable: assert property (
		$fell(select_n) ##1 !select_n[*3] |-> serial_out_oe) else $error("no drive");
	a_out_release: assert property (
		$rose(select_n) ##1 select_n[*3] |-> !serial_out_oe) else $error("not hi-z");
	a_busy_flag: assert property (
		converting && serial_out_oe |-> serial_out) else $error("busy not shown");
	// entry from sleep into the transfer: port driven, done shown
	a_done_flag: assert property (
		$fell(sleeping) && !converting && !power_on_clear
		|-> serial_out_oe && !serial_out) else $error("done not shown");
	a_cfg_changes: assert property (
		$changed({channel_sel, rejection, speed_2x, temp_sensor, gain})
		|-> $rose(converting) || power_on_clear) else $error("config moved");
	a_cal_first: assert property (
		$rose(converting) |-> cal_phase == adc_cycle_pkg::cal_offset)
		else $error("no offset phase");
	a_por_defaults: assert property (
		$rose(converting) && $past(power_on_clear) |-> channel_sel == 5'h00
		&& gain == 3'h0 && rejection == 2'h0 && !speed_2x && !temp_sensor)
		else $error("bad defaults");
	a_ext_no_drive: assert property (
		!internal_clock_mode |-> !shift_clock_oe) else $error("clock driven");
endmodule

bind adc_serial_conversion_cycle adc_cycle_monitor adc_cycle_monitor_i (
	.clk, .rst_n, .supply_ok, .select_n, .shift_clock_in, .shift_clock_out,
	.shift_clock_oe, .serial_in, .serial_out, .serial_out_oe, .conv_raw,
	.power_on_clear, .converting, .sleeping, .cal_phase, .internal_clock_mode,
	.channel_sel, .rejection, .speed_2x, .temp_sensor, .gain
);

// File: sim/host_model.sv
// host side of the serial port: select, shift clock pin, config input
// assumes a pull-up on the shift clock pin, so a floated pin reads high
`timescale 1ns/1ps
module host_model (
	input  wire logic clk,
	input  wire logic shift_clock_out,
	input  wire logic shift_clock_oe,
	input  wire logic serial_out,
	input  wire logic serial_out_oe,
	output logic      select_n,
	output logic      serial_in,
	output wire logic shift_clock_pin
);
	logic sck_en = 1'b1;
	logic sck_drv = 1'b0;
	// pin level: device first, then host, then the pull-up
	assign shift_clock_pin = shift_clock_oe ? shift_clock_out
		: (sck_en ? sck_drv : 1'b1);
	initial begin
		select_n = 1'b1;
		serial_in = 1'b0;
	end
	// status read without clocks
	task automatic peek(output logic so, output logic oe);
		@(posedge clk);
		#2 select_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 so = serial_out;
		oe = serial_out_oe;
		#1 select_n = 1'b1;
		serial_in = ~serial_in;
	endtask
	// one transfer; ext holds the pin low, else floats it
	task automatic frame(input logic ext, input int rises,
		input logic [15:0] cfg, output logic [23:0] word, output int seen);
		int i;
		logic prev;
		word = '0;
		seen = 0;
		sck_en = ext;
		sck_drv = 1'b0;
		repeat (4) @(posedge clk);
		#2 select_n = 1'b0;
		serial_in = cfg[15];
		repeat (5) @(posedge clk);
		if (ext) begin
			// 12 ns link clock, only inside the frame
			for (i = 0; i < rises; i++) begin
				#6 sck_drv = 1'b1;
				word = {word[22:0], serial_out};
				#6 sck_drv = 1'b0;
				serial_in = (i < 15) ? cfg[14 - i] : 1'b0;
			end
			seen = rises;
		end else begin
			prev = shift_clock_pin;
			for (i = 0; i < 1200 && !(seen == 24 && !prev); i++) begin
				@(posedge clk);
				#1;
				if (shift_clock_pin && !prev) begin
					seen++;
					word = {word[22:0], serial_out};
				end
				if (!shift_clock_pin && prev)
					serial_in = (seen < 16) ? cfg[15 - seen] : 1'b0;
				prev = shift_clock_pin;
			end
		end
		repeat (5) @(posedge clk);
		#2 select_n = 1'b1;
		serial_in = ~serial_in;
	endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for the conversion-cycle sequencer
// assumes host_model on the port and the checker bound to the top
`timescale 1ns/1ps
module testbench;
	localparam int POR  = 20;
	localparam int CONV = 30;
	logic                         clk = 1'b0;
	logic                         rst_n = 1'b0;
	logic                         supply_ok = 1'b1;
	logic signed [19:0]           conv_raw = 20'sh0_1234;
	logic                         select_n, serial_in, sck_pin;
	logic                         shift_clock_out, shift_clock_oe;
	logic                         serial_out, serial_out_oe, power_on_clear;
	logic                         converting, sleeping, internal_clock_mode;
	logic                         speed_2x, temp_sensor;
	logic [4:0]                   channel_sel;
	logic [1:0]                   rejection;
	logic [2:0]                   gain;
	adc_cycle_pkg::cal_phase_type cal_phase;
	int                           miscompares = 0;
	int                           checks = 0;
	logic signed [19:0]           raws [5] = '{20'sh0_1234, -20'sh0_0005,
		20'sh7_FFFF, 20'sh8_0000, 20'sh0_0000};
	logic [15:0]                  cfgs [4] = '{16'hAEA8, 16'hDF7C,
		16'h8204, 16'hFFFC};
	logic [3:0]                   exts = 4'hB;
	wire logic [11:0] cfg_now = {channel_sel, rejection, speed_2x,
		temp_sensor, gain};

	always #25 clk = ~clk;

	adc_serial_conversion_cycle #(.POR_CYCLES(POR), .CONV_CYCLES(CONV),
		.SCK_HALF(10)) adc_serial_conversion_cycle_i (
		.clk, .rst_n, .supply_ok, .select_n, .shift_clock_in(sck_pin),
		.shift_clock_out, .shift_clock_oe, .serial_in, .serial_out,
		.serial_out_oe, .conv_raw, .power_on_clear, .converting, .sleeping,
		.cal_phase, .internal_clock_mode, .channel_sel, .rejection,
		.speed_2x, .temp_sensor, .gain);
	host_model host_i (.clk, .shift_clock_out, .shift_clock_oe, .serial_out,
		.serial_out_oe, .select_n, .serial_in, .shift_clock_pin(sck_pin));

	// expected word: clamp to one lsb beyond full scale either side
	function automatic logic [23:0] exp_word(input logic signed [19:0] r);
		logic signed [17:0] c;
		if (r > 20'sh1_0000) c = 18'sh1_0000;
		else if (r < -20'sh1_0001) c = -18'sh1_0001;
		else c = r[17:0];
		return {2'h0, ~c[17], c[16:0], 4'h0};
	endfunction
	function automatic logic [11:0] exp_cfg(input logic [15:0] c);
		return {c[14:10], c[7:6], c[5], c[8], c[4:2]};
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp,
		input string what);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s: %h, expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// bounded wait: 0 for converting, 1 for sleeping
	task automatic wait_on(input int which, input int bound);
		for (int n = 0; n < bound; n++) begin
			@(posedge clk);
			#1;
			if (which == 0 ? converting === 1'b1 : sleeping === 1'b1)
				return;
		end
		$display("[FAIL] %0t wait ran out", $time);
		miscompares++;
		stop_test();
	endtask

	task automatic t_power_up();
		int n;
		logic so, oe;
		repeat (10) @(posedge clk);
		#1 check(power_on_clear, 1'b1, "clear in reset");
		#1 rst_n = 1'b1;
		// sampled off the edge, so the loop never races the state update
		for (n = 0; power_on_clear === 1'b1 && n < 100; n++) begin
			@(posedge clk);
			#1 if (n < 3) check(serial_out_oe, 1'b0, "idle port");
		end
		check(n >= POR && n <= POR + 4, 1'b1, "clear length");
		check(converting, 1'b1, "first conversion");
		check(cfg_now, 12'h000, "defaults");
		host_i.peek(so, oe);
		check({oe, so}, 2'h3, "busy status");
		wait_on(1, CONV + 10);
	endtask
	// a word per conversion; sleep input changes must not leak in
	task automatic t_frames();
		logic [23:0] word;
		int seen;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			#2 conv_raw = ~raws[i];
			repeat (20) @(posedge clk);
			host_i.frame(exts[i], 24, cfgs[i], word, seen);
			conv_raw = raws[i + 1];
			check(word, exp_word(raws[i]), "word");
			check(seen[23:0], 24, "pulses");
			check(shift_clock_oe, 1'b0, "clock stopped");
			check(internal_clock_mode, !exts[i], "clock mode");
			wait_on(0, 10);
			check(cfg_now, exp_cfg(cfgs[i]), "config");
			wait_on(1, CONV + 10);
			check(serial_out_oe, 1'b0, "released");
		end
	endtask
	task automatic t_abort();
		logic [23:0] word;
		int seen;
		host_i.frame(1'b1, 0, 16'h0000, word, seen);
		repeat (6) @(posedge clk);
		#1 check({sleeping, converting}, 2'h2, "quiet abort");
		host_i.frame(1'b1, 1, 16'h0000, word, seen);
		wait_on(0, 10);
		check(cfg_now, exp_cfg(cfgs[3]), "config kept");
		wait_on(1, CONV + 10);
	endtask
	task automatic t_supply();
		@(posedge clk);
		#2 supply_ok = 1'b0;
		repeat (5) @(posedge clk);
		#1 check(power_on_clear, 1'b1, "supply low");
		#1 supply_ok = 1'b1;
		wait_on(0, POR + 20);
		check(cfg_now, 12'h000, "cleared config");
		check(internal_clock_mode, 1'b0, "cleared mode");
	endtask

	initial begin
		t_power_up();
		t_frames();
		t_abort();
		t_supply();
		stop_test();
	end
endmodule
